// ### logic/mis_sender.sv
// Modem init serial sender: sends the stored command string once after
// reset. Assumes the string store answers a read one cycle after the
// address (registered read) and that mode strap is stable at release.
`timescale 1ns/10ps
module mis_sender #(
  parameter int unsigned LEN     = mis_pkg::STR_LEN,
  parameter int unsigned DEPTH   = mis_pkg::FIFO_DEPTH,
  parameter int unsigned BIT_LEN = mis_pkg::BIT_CYCLES
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  // Configuration straps
  input  wire mis_pkg::mis_init_mode_t      initMode,
  input  wire logic                         otherProtocol,
  // Command string store
  output logic       [mis_pkg::ADDR_W-1:0]  strAddr,
  input  wire logic  [mis_pkg::WORD_W-1:0]  strData,
  input  wire logic                         strSet,
  // Serial link
  output logic                              txLine,
  input  wire logic                         rxLine,
  // Indicators and status
  output logic                              transmit_activity_indicator,
  output logic                              receiveActivity,
  output logic                              maintenanceEnable,
  output logic                              comm_error_flag,
  output logic       [15:0]                 comm_error_code_reg,
  output logic                              initDone
);
  import mis_pkg::*;

  // Receive stretch scales with the bit time chosen for this instance.
  localparam int unsigned HOLD_LEN = (RX_FLASH_CYCLES / BIT_CYCLES) * BIT_LEN;

  mis_state_t       state_q;
  mis_tx_state_t    txState_q;
  mis_init_mode_t   mode_q;
  logic             caught_q;
  logic             other_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]       lastChar_q;
  logic [7:0]       prevChar_q;
  logic [BIT_CNT_W-1:0] bitCnt_q;
  logic [3:0]       bitIdx_q;
  logic [8:0]       shift_q;
  logic             txLine_q;
  logic             txBusy;
  logic             fifoInValid;
  logic             fifoInReady;
  logic             fifoOutValid;
  logic             fifoOutReady;
  logic [7:0]       fifoOutData;
  logic             bitEnd;
  logic             rxSeen_q;
  logic [BIT_CNT_W:0] rxHold_q;
  logic             rxLine_q;

  function automatic logic uses_string(input mis_init_mode_t m);
    return (m != MIS_INIT_OFF);
  endfunction

  // Settings are caught once; later strap changes are ignored until reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      caught_q <= 1'b0;
      mode_q   <= MIS_INIT_OFF;
      other_q  <= 1'b0;
    end else if (!caught_q) begin
      caught_q <= 1'b1;
      mode_q   <= initMode;
      other_q  <= otherProtocol;
    end
  end

  assign maintenanceEnable = caught_q && !other_q;

  // Fetch sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= MIS_IDLE;
      addr_q     <= '0;
      lastChar_q <= 8'h00;
      prevChar_q <= 8'h00;
    end else begin
      unique case (state_q)
        MIS_IDLE: begin
          if (caught_q && !other_q && uses_string(mode_q)) begin
            state_q <= MIS_FETCH;
            addr_q  <= '0;
          end
        end
        MIS_FETCH: state_q <= MIS_WAIT;
        MIS_WAIT: begin
          if (!strSet) begin
            state_q <= MIS_DRAIN;
          end else begin
            state_q <= MIS_PUSH;
          end
        end
        MIS_PUSH: begin
          if (fifoInReady) begin
            prevChar_q <= lastChar_q;
            lastChar_q <= strData[7:0];
            if (addr_q == ADDR_W'(LEN-1)) begin
              state_q <= MIS_DRAIN;
            end else begin
              addr_q  <= addr_q + 1'b1;
              state_q <= MIS_FETCH;
            end
          end
        end
        MIS_DRAIN: begin
          if (!fifoOutValid && !txBusy) begin
            state_q <= (prevChar_q == CHAR_CR && lastChar_q == CHAR_LF)
                       ? MIS_DONE : MIS_FAIL;
          end
        end
        MIS_DONE: state_q <= MIS_DONE;
        MIS_FAIL: state_q <= MIS_FAIL;
        default:  state_q <= MIS_IDLE;
      endcase
    end
  end

  assign strAddr     = addr_q;
  assign fifoInValid = (state_q == MIS_PUSH);
  assign initDone    = (state_q == MIS_DONE);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      comm_error_flag     <= 1'b0;
      comm_error_code_reg <= ERR_NONE;
    end else if (state_q == MIS_DRAIN && !fifoOutValid && !txBusy &&
                 !(prevChar_q == CHAR_CR && lastChar_q == CHAR_LF)) begin
      comm_error_flag     <= 1'b1;
      comm_error_code_reg <= ERR_MODEM_INIT;
    end
  end

  mis_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .arst_n   (arst_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (strData[7:0]),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // Frame shape follows the caught mode.
  assign bitEnd       = (bitCnt_q == BIT_CNT_W'(BIT_LEN-1));
  assign txBusy       = (txState_q != MIS_TX_IDLE);
  assign fifoOutReady = !txBusy;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txState_q <= MIS_TX_IDLE;
      bitCnt_q  <= '0;
      bitIdx_q  <= '0;
      shift_q   <= '0;
      txLine_q  <= 1'b1;
    end else begin
      bitCnt_q <= (txBusy && !bitEnd) ? bitCnt_q + 1'b1 : '0;
      unique case (txState_q)
        MIS_TX_IDLE: begin
          txLine_q <= 1'b1;
          if (fifoOutValid) begin
            // User mode: 7 data bits then even parity in the eighth slot.
            shift_q <= (mode_q == MIS_INIT_USER)
                       ? {1'b1, ^fifoOutData[6:0], fifoOutData[6:0]}
                       : {1'b1, fifoOutData};
            txState_q <= MIS_TX_START;
            txLine_q  <= 1'b0;
          end
        end
        MIS_TX_START: begin
          if (bitEnd) begin
            txState_q <= MIS_TX_DATA;
            bitIdx_q  <= '0;
            txLine_q  <= shift_q[0];
            shift_q   <= {1'b1, shift_q[8:1]};
          end
        end
        MIS_TX_DATA: begin
          if (bitEnd) begin
            if (bitIdx_q == FRAME_SLOTS - 4'h1) begin
              txState_q <= MIS_TX_STOP;
              txLine_q  <= 1'b1;
            end else begin
              bitIdx_q <= bitIdx_q + 1'b1;
              txLine_q <= shift_q[0];
              shift_q  <= {1'b1, shift_q[8:1]};
            end
          end
        end
        MIS_TX_STOP: begin
          if (bitEnd) begin
            txState_q <= MIS_TX_IDLE;
          end
        end
      endcase
    end
  end

  assign txLine                      = txLine_q;
  assign transmit_activity_indicator = txBusy;

  // Receive indicator stretches each low pulse, in string modes with maintenance enabled, so short bits stay visible.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxLine_q <= 1'b1;
      rxHold_q <= '0;
      rxSeen_q <= 1'b0;
    end else begin
      rxLine_q <= rxLine;
      if (!rxLine_q && maintenanceEnable && uses_string(mode_q)) begin
        rxHold_q <= (BIT_CNT_W+1)'(HOLD_LEN);
      end else if (rxHold_q != '0) begin
        rxHold_q <= rxHold_q - 1'b1;
      end
      rxSeen_q <= (rxHold_q != '0);
    end
  end

  assign receiveActivity = rxSeen_q;

  // Assertions
  sequence frame_start_s;
    txState_q == MIS_TX_IDLE && fifoOutValid;
  endsequence

  no_send_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    (caught_q && mode_q == MIS_INIT_OFF) |-> !txBusy && !receiveActivity)
    else $error("activity with initialization off");
  start_low_a: assert property (@(posedge clk) disable iff (!arst_n)
    frame_start_s |=> !txLine)
    else $error("start bit not low");
  stop_high_a: assert property (@(posedge clk) disable iff (!arst_n)
    txState_q == MIS_TX_STOP |-> txLine)
    else $error("stop bit not high");
  empty_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == MIS_WAIT && !strSet) |=> state_q == MIS_DRAIN)
    else $error("empty word did not end fetch");
  other_proto_a: assert property (@(posedge clk) disable iff (!arst_n)
    (caught_q && other_q) |-> !maintenanceEnable && state_q == MIS_IDLE)
    else $error("service on other protocol");
  err_code_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(comm_error_flag) |-> comm_error_code_reg == ERR_MODEM_INIT)
    else $error("wrong error code");
  fail_no_done_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    comm_error_flag |-> !initDone)
    else $error("failed string reported done");
  mode_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    caught_q |=> $stable(mode_q))
    else $error("mode changed without restart");
  one_frame_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(txBusy) |-> $past(txState_q) == MIS_TX_STOP && $past(bitEnd))
    else $error("frame ended before its stop bit");
endmodule

// ### shared/mis_pkg.sv
// Constants and types for the modem init serial sender.
// Assumes a 100 MHz system clock and 16-bit data register words.
package mis_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BAUD_BPS     = 9600;
  // Cycles per bit, rounded down to the nearest whole cycle.
  localparam int unsigned BIT_CYCLES   = CLK_HZ / BAUD_BPS;
  localparam int unsigned BIT_CNT_W    = 14;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned STR_LEN      = 60;
  localparam logic [7:0]  CHAR_CR      = 8'h0d;
  localparam logic [7:0]  CHAR_LF      = 8'h0a;
  localparam logic [15:0] ERR_NONE     = 16'h0000;
  // Modem initialization failure, 6307 decimal.
  localparam logic [15:0] ERR_MODEM_INIT = 16'h18a3;
  localparam int unsigned FIFO_DEPTH   = 8;
  // Stretch of the receive indicator after the line was last seen low.
  localparam int unsigned RX_FLASH_CYCLES = 2 * BIT_CYCLES;
  // Bit slots between start and stop; user mode puts parity in the last.
  localparam logic [3:0]  FRAME_SLOTS  = 4'h8;

  typedef enum logic [1:0] {
    MIS_INIT_OFF  = 2'h0,
    MIS_INIT_USER = 2'h1,
    MIS_INIT_PEER1 = 2'h2,
    MIS_INIT_PEER2 = 2'h3
  } mis_init_mode_t;

  typedef enum logic [2:0] {
    MIS_IDLE  = 3'b000,
    MIS_FETCH = 3'b001,
    MIS_WAIT  = 3'b011,
    MIS_PUSH  = 3'b010,
    MIS_DRAIN = 3'b110,
    MIS_DONE  = 3'b111,
    MIS_FAIL  = 3'b101
  } mis_state_t;

  typedef enum logic [1:0] {
    MIS_TX_IDLE  = 2'b00,
    MIS_TX_START = 2'b01,
    MIS_TX_DATA  = 2'b11,
    MIS_TX_STOP  = 2'b10
  } mis_tx_state_t;
endpackage

// ### logic/mis_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data come straight from the storage flops.
`timescale 1ns/10ps
module mis_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_q[rdPtr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ### tb/mis_modem_model.sv
// Modem on the far side of the serial link: decodes sent frames and
// can answer with one character. Assumes the bench sets the format.
`timescale 1ns/10ps
module mis_modem_model
  import mis_pkg::*;
#(
  parameter logic [7:0]  REPLY   = 8'h4f,
  parameter int unsigned BIT_LEN = BIT_CYCLES
) (
  // Clock
  input  wire logic       clk,
  // Link
  input  wire logic       txLine,
  output logic            rxLine,
  input  wire logic       txInd,
  // Bench control
  input  wire logic       sevenBit,
  input  wire logic       respond,
  // Decoded character
  output logic            gotChar,
  output logic [7:0]      charData,
  output logic            frameOk,
  output logic            indSeen
);
  logic [8:0] sh;

  initial begin
    gotChar = 1'b0;
    charData = 8'h00;
    frameOk = 1'b0;
    indSeen = 1'b0;
    forever begin
      @(negedge txLine);
      repeat (BIT_LEN / 2) @(posedge clk);
      indSeen = txInd;
      // Mid-bit sampling keeps clear of the edges
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_LEN) @(posedge clk);
        sh[i] = txLine;
      end
      charData = sevenBit ? {1'b0, sh[6:0]} : sh[7:0];
      frameOk = sh[8] & (~sevenBit | ~^sh[7:0]);
      #1 gotChar = 1'b1;
      @(posedge clk);
      #1 gotChar = 1'b0;
    end
  end

  // Answer in 8N1 with no control lines
  initial begin
    rxLine = 1'b1;
    forever begin
      @(posedge respond);
      for (int i = 0; i < 10; i++) begin
        @(posedge clk);
        #1 rxLine = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : REPLY[i-1];
        repeat (BIT_LEN - 1) @(posedge clk);
      end
    end
  end
endmodule

// ### tb/tb.sv
// Self-checking bench for the modem init sender.
// Assumes a registered-read string store modelled here.
`timescale 1ns/10ps
module tb;
  import mis_pkg::*;
  // Short bit time keeps the run small; the frame shape is unchanged.
  localparam int unsigned BIT = 64;
  logic                clk, arst_n, otherProtocol, strSet, sevenBit, respond;
  mis_init_mode_t      initMode;
  logic [ADDR_W-1:0]   strAddr;
  logic [WORD_W-1:0]   strData;
  logic                txLine, rxLine, txInd, rxAct, maint, errFlag, initDone;
  logic                gotChar, frameOk, indSeen;
  logic [15:0]         errCode;
  logic [7:0]          charData;
  logic [WORD_W-1:0]   mem [0:STR_LEN-1];
  logic [STR_LEN-1:0]  memSet;
  logic [7:0]          expQ [$];
  int                  num_errors, checked;
  logic [31:0]         seed = 32'h00017544;

  mis_sender #(.BIT_LEN(BIT)) i_mis_sender (.clk(clk), .arst_n(arst_n),
    .initMode(initMode),
    .otherProtocol(otherProtocol), .strAddr(strAddr), .strData(strData),
    .strSet(strSet), .txLine(txLine), .rxLine(rxLine),
    .transmit_activity_indicator(txInd), .receiveActivity(rxAct),
    .maintenanceEnable(maint), .comm_error_flag(errFlag),
    .comm_error_code_reg(errCode), .initDone(initDone));
  mis_modem_model #(.BIT_LEN(BIT)) i_mis_modem_model (.clk(clk),
    .txLine(txLine),
    .rxLine(rxLine), .txInd(txInd), .sevenBit(sevenBit), .respond(respond),
    .gotChar(gotChar), .charData(charData), .frameOk(frameOk),
    .indSeen(indSeen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always_ff @(posedge clk) begin
    strData <= mem[strAddr];
    strSet <= memSet[strAddr];
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Words past the empty one stay set so a missed stop shows up
  task automatic load(input int n, input logic term, input logic seven);
    for (int i = 0; i < STR_LEN; i++) begin
      mem[i] = WORD_W'(xs());
      memSet[i] = (i != n);
    end
    if (term) begin
      mem[n-2][7:0] = CHAR_CR;
      mem[n-1][7:0] = CHAR_LF;
    end
    for (int i = 0; i < n; i++) begin
      expQ.push_back(seven ? {1'b0, mem[i][6:0]} : mem[i][7:0]);
    end
  endtask

  task automatic start(input mis_init_mode_t m, input logic o);
    @(posedge clk);
    #1 arst_n = 1'b0;
    initMode = m;
    otherProtocol = o;
    sevenBit = (m == MIS_INIT_USER);
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
  endtask

  task automatic quiet();
    logic act;
    act = 1'b0;
    repeat (300) begin
      @(posedge clk);
      act = act | txInd | ~txLine | rxAct;
    end
    check({15'h0, act}, 16'h0000);
  endtask

  task automatic wait_idle(input int frames);
    int k;
    k = 0;
    while ((expQ.size() > 0 || txInd !== 1'b0) &&
           k < frames * 11 * BIT) begin
      @(posedge clk);
      k++;
    end
    if (k >= frames * 11 * BIT) begin
      num_errors++;
      wrap_up();
    end
    repeat (20) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (gotChar === 1'b1) begin
      check({15'h0, expQ.size() > 0}, 16'h0001);
      if (expQ.size() > 0) check({8'h00, charData}, {8'h00, expQ.pop_front()});
      check({15'h0, frameOk}, 16'h0001);
      check({15'h0, indSeen}, 16'h0001);
    end
  end

  initial begin
    arst_n = 1'b0;
    initMode = MIS_INIT_OFF;
    otherProtocol = 1'b0;
    sevenBit = 1'b0;
    respond = 1'b0;
    num_errors = 0;
    checked = 0;
    load(2, 1'b1, 1'b0);
    expQ.delete();
    start(MIS_INIT_OFF, 1'b0);
    respond = 1'b1;
    quiet();
    #1 respond = 1'b0;
    $display("Test init off done");
    start(MIS_INIT_USER, 1'b1);
    quiet();
    check({15'h0, maint}, 16'h0000);
    $display("Test other protocol done");
    load(3, 1'b1, 1'b1);
    start(MIS_INIT_USER, 1'b0);
    repeat (3) @(posedge clk);
    #1 initMode = MIS_INIT_PEER1;
    wait_idle(3);
    check({15'h0, initDone}, 16'h0001);
    check({15'h0, errFlag}, 16'h0000);
    check(errCode, ERR_NONE);
    check({15'h0, maint}, 16'h0001);
    #1 respond = 1'b1;
    repeat (3 * BIT) @(posedge clk);
    check({14'h0, rxAct, txInd}, 16'h0002);
    #1 respond = 1'b0;
    repeat (14 * BIT) @(posedge clk);
    check({15'h0, rxAct}, 16'h0000);
    $display("Test user mode done");
    for (int m = 2; m < 4; m++) begin
      load(1, 1'b0, 1'b0);
      start(mis_init_mode_t'(m), 1'b0);
      wait_idle(2);
      check({15'h0, initDone}, 16'h0000);
      check({15'h0, errFlag}, 16'h0001);
      check(errCode, ERR_MODEM_INIT);
      $display("Test peer mode %0d done", m - 1);
    end
    load(STR_LEN, 1'b1, 1'b0);
    start(MIS_INIT_PEER2, 1'b0);
    wait_idle(STR_LEN);
    check({15'h0, initDone}, 16'h0001);
    check({15'h0, errFlag}, 16'h0000);
    $display("Test full string done");
    wrap_up();
  end
endmodule
